// File: logic/sci_uart_control_options.sv
// Operation
// - loop select routes transmitter into receiver
// - receiver source ignored without loop mode
// - source picks internal loop or single wire
// - wait-stop bit freezes clocks in wait
// - character length bit adds ninth data bit
// - wakeup method: idle line or address mark
// - idle type picks where idle counting starts
// - parity enable: generate, check, MSB is parity
// - parity type: even at zero, odd at one
// - interrupt on buffer empty or complete, enabled
// - interrupt on receive full or idle, enabled
// - transmitter works and drives pin while enabled
// - single wire direction bit sets pin drive
// - enable cleared then set queues idle character
// - pin held until pending activity finishes
// - receive enable; pin released off or looped
// - standby set by software, cleared on wakeup
// - send break queues breaks of set length
// - second break may queue before bit clears
// - buffer empty flag set at reset, on transfer
// - complete flag set when empty and inactive
// - idle flag sets once per received character
// - rate is clock over sixteen times divisor
`timescale 1ns/1ps
`default_nettype none

module sci_uart_control_options
   import sci_uart_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // register port
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output var  logic [7:0] rdata,
   // serial pins
   output var  logic       tx_pin_out,
   output var  logic       tx_pin_oe,
   input  wire logic       tx_pin_in,
   input  wire logic       rx_pin_in,
   output var  logic       rx_pin_owned,
   // system
   input  wire logic       wait_mode,
   output var  logic       irq
);

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic ones_odd(input logic [8:0] v);
      ones_odd = ^v;
   endfunction

   function automatic logic [3:0] char_len(input logic nine);
      char_len = nine ? CHAR_BITS_9 : CHAR_BITS_8;
   endfunction

   // ------------------------------
   // state
   // ------------------------------
   ctrl_options_s opt_r;
   ctrl_enables_s en_r;
   logic [4:0]    div_hi_buf_r;
   logic [12:0]   divisor_r;
   logic [12:0]   baud_cnt_r;
   logic          tick_r;
   logic [2:0]    extra_r;
   logic [7:0]    tx_buf_r;
   logic          tx_buf_ninth_r;
   logic          tx_buffer_empty_flag_r;
   logic          tc_r;
   logic          idle_pend_r;
   logic          brk_pend_r;
   tx_state_e     tx_state_r;
   logic [13:0]   tx_frame_r;
   logic [3:0]    tx_bits_r;
   logic [3:0]    tx_ph_r;
   logic          tx_brk_r;
   logic          tx_line_r;
   rx_state_e     rx_state_r;
   logic [3:0]    rx_ph_r;
   logic [3:0]    rx_cnt_r;
   logic [8:0]    rx_sh_r;
   logic [3:0]    idle_cnt_r;
   logic          idle_armed_r;
   logic [7:0]    rx_data_r;
   logic          rx_ninth_r;
   logic          rx_buffer_full_flag_r;
   logic          idle_r;
   logic          overrun_r;
   logic          framing_r;
   logic          parity_err_r;
   logic          rd_armed_r;

   logic          run;
   logic          tick;
   logic          rx_in;
   logic          tx_start;
   logic          tx_done;
   logic          rx_done;
   logic          rx_accept;
   logic          rx_clear;
   logic          wake_idle;
   logic          wr_en;
   logic [7:0]    tx_data_p;
   logic          tx_ninth_p;

   // ------------------------------
   // clock freeze, rate generator, input routing
   // ------------------------------
   assign run   = !(wait_mode && opt_r.wait_clock_freeze);
   assign tick  = tick_r && run;
   assign wr_en = wr && (addr == OFS_ENABLES);

   // loop source only matters with loop selected
   always_comb
   begin
      if (!opt_r.loop_select)
         rx_in = rx_pin_in;
      else if (opt_r.receiver_source_select)
         rx_in = tx_pin_in;
      else
         rx_in = tx_line_r;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         baud_cnt_r <= 13'h0000;
         tick_r     <= 1'b0;
      end
      else if (divisor_r == 13'h0000)
      begin
         baud_cnt_r <= 13'h0000;
         tick_r     <= 1'b0;
      end
      else if (!run)
         tick_r <= 1'b0;
      else if (baud_cnt_r >= divisor_r - 13'h0001)
      begin
         baud_cnt_r <= 13'h0000;
         tick_r     <= 1'b1;
      end
      else
      begin
         baud_cnt_r <= baud_cnt_r + 13'h0001;
         tick_r     <= 1'b0;
      end
   end

   // ------------------------------
   // control registers
   // ------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         opt_r        <= ctrl_options_s'(RST_OPTIONS);
         div_hi_buf_r <= RST_DIVISOR[12:8];
         divisor_r    <= RST_DIVISOR;
         extra_r      <= 3'h0;
      end
      else if (wr)
      begin
         case (addr)
            OFS_OPTIONS: opt_r        <= ctrl_options_s'(wdata);
            OFS_DIV_HI:  div_hi_buf_r <= wdata[4:0];
            OFS_DIV_LO:  divisor_r    <= {div_hi_buf_r, wdata};
            OFS_EXTRA:   extra_r      <= wdata[2:0];
            default:     opt_r        <= opt_r;
         endcase
      end
   end

   // hardware wakeup clear wins over a software write in the same cycle
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         en_r <= ctrl_enables_s'(RST_ENABLES);
      else
      begin
         if (wr_en)
            en_r <= ctrl_enables_s'(wdata);
         if (wake_idle || (rx_done && en_r.receiver_standby
                           && opt_r.wake_address_mark && rx_sh_r[8]))
            en_r.receiver_standby <= 1'b0;
      end
   end

   // ------------------------------
   // transmit queueing
   // ------------------------------
   assign tx_done  = (tx_state_r == TX_SHIFT) && tick && (tx_ph_r == TICKS_LAST)
                     && (tx_bits_r == 4'h1);
   assign tx_start = (tx_state_r == TX_IDLE) && tick
                     && (idle_pend_r || brk_pend_r || (!tx_buffer_empty_flag_r && en_r.transmit_enable));

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         idle_pend_r <= 1'b0;
         brk_pend_r  <= 1'b0;
      end
      else
      begin
         if (tx_start && idle_pend_r)
            idle_pend_r <= 1'b0;
         else if (tx_start && brk_pend_r)
            brk_pend_r <= 1'b0;
         if (tx_done && tx_brk_r && en_r.send_break)
            brk_pend_r <= 1'b1;
         if (wr_en && wdata[3] && !en_r.transmit_enable)
            idle_pend_r <= 1'b1;
         if (wr_en && wdata[0])
            brk_pend_r <= 1'b1;
      end
   end

   // data path with parity placed in the top data bit
   always_comb
   begin
      tx_data_p  = tx_buf_r;
      tx_ninth_p = tx_buf_ninth_r;
      if (opt_r.parity_enable && opt_r.nine_bit_mode)
         tx_ninth_p = ones_odd({1'b0, tx_buf_r}) ^ opt_r.parity_odd_select;
      else if (opt_r.parity_enable)
         tx_data_p[7] = ones_odd({2'b00, tx_buf_r[6:0]})
                        ^ opt_r.parity_odd_select;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_buf_r       <= 8'h00;
         tx_buf_ninth_r <= 1'b0;
         tx_buffer_empty_flag_r         <= 1'b1;
      end
      else
      begin
         if (wr && (addr == OFS_DATA))
         begin
            tx_buf_r       <= wdata;
            tx_buf_ninth_r <= extra_r[EX_TX_NINTH];
            tx_buffer_empty_flag_r         <= 1'b0;
         end
         if (tx_start && !idle_pend_r && !brk_pend_r)
            tx_buffer_empty_flag_r <= 1'b1;
      end
   end

   // ------------------------------
   // transmit shifter
   // ------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_state_r <= TX_IDLE;
         tx_frame_r <= 14'h3FFF;
         tx_bits_r  <= 4'h0;
         tx_ph_r    <= 4'h0;
         tx_brk_r   <= 1'b0;
      end
      else
      begin
         case (tx_state_r)
            TX_IDLE:
            begin
               if (tx_start)
               begin
                  tx_state_r <= TX_SHIFT;
                  tx_ph_r    <= 4'h0;
                  tx_brk_r   <= 1'b0;
                  tx_bits_r  <= char_len(opt_r.nine_bit_mode);
                  if (idle_pend_r)
                     tx_frame_r <= 14'h3FFF;
                  else if (brk_pend_r)
                  begin
                     tx_frame_r <= 14'h0000;
                     tx_brk_r   <= 1'b1;
                     if (extra_r[EX_LONG_BRK])
                        tx_bits_r <= char_len(opt_r.nine_bit_mode)
                                     + LONG_BRK_ADD;
                  end
                  else if (opt_r.nine_bit_mode)
                     tx_frame_r <= {3'b111, 1'b1, tx_ninth_p, tx_data_p, 1'b0};
                  else
                     tx_frame_r <= {4'b1111, 1'b1, tx_data_p, 1'b0};
               end
            end
            TX_SHIFT:
            begin
               if (tick)
               begin
                  tx_ph_r <= tx_ph_r + 4'h1;
                  if (tx_ph_r == TICKS_LAST)
                  begin
                     tx_frame_r <= {1'b1, tx_frame_r[13:1]};
                     tx_bits_r  <= tx_bits_r - 4'h1;
                     if (tx_bits_r == 4'h1)
                        tx_state_r <= TX_IDLE;
                  end
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   // outside single-wire listen, pin stays ours while enabled or while anything is still going out
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_line_r  <= 1'b1;
         tx_pin_out <= 1'b1;
         tx_pin_oe  <= 1'b0;
         tc_r       <= 1'b1;
      end
      else
      begin
         tx_line_r  <= (tx_state_r == TX_SHIFT) ? tx_frame_r[0] : 1'b1;
         tx_pin_out <= (tx_state_r == TX_SHIFT) ? tx_frame_r[0] : 1'b1;
         tc_r       <= tx_buffer_empty_flag_r && (tx_state_r == TX_IDLE) && !tx_start
                       && !idle_pend_r && !brk_pend_r;
         if (opt_r.loop_select && opt_r.receiver_source_select
             && !extra_r[EX_SW_DIR])
            tx_pin_oe <= 1'b0;
         else
            tx_pin_oe <= en_r.transmit_enable || (tx_state_r == TX_SHIFT)
                         || idle_pend_r || brk_pend_r;
      end
   end

   // ------------------------------
   // receiver
   // ------------------------------
   assign rx_done   = (rx_state_r == RX_STOP) && tick && (rx_ph_r == TICKS_LAST);
   assign rx_accept = rx_done && (!en_r.receiver_standby
                      || (opt_r.wake_address_mark && rx_sh_r[8]));
   assign wake_idle = (rx_state_r == RX_IDLE) && !opt_r.wake_address_mark
                      && en_r.receiver_standby
                      && (idle_cnt_r == char_len(opt_r.nine_bit_mode));

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_state_r <= RX_IDLE;
         rx_ph_r    <= 4'h0;
         rx_cnt_r   <= 4'h0;
         rx_sh_r    <= 9'h000;
      end
      else if (!en_r.receive_enable)
         rx_state_r <= RX_IDLE;
      else if (tick)
      begin
         rx_ph_r <= rx_ph_r + 4'h1;
         case (rx_state_r)
            RX_IDLE:
            begin
               if (!rx_in)
               begin
                  rx_state_r <= RX_START;
                  rx_ph_r    <= 4'h0;
               end
            end
            RX_START:
            begin
               if (rx_ph_r == TICKS_MID)
               begin
                  rx_ph_r    <= 4'h0;
                  rx_cnt_r   <= 4'h0;
                  rx_state_r <= rx_in ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA:
            begin
               if (rx_ph_r == TICKS_LAST)
               begin
                  rx_sh_r  <= {rx_in, rx_sh_r[8:1]};
                  rx_cnt_r <= rx_cnt_r + 4'h1;
                  if (rx_cnt_r == char_len(opt_r.nine_bit_mode) - 4'h3)
                     rx_state_r <= RX_STOP;
               end
            end
            RX_STOP:
            begin
               if (rx_ph_r == TICKS_LAST)
                  rx_state_r <= RX_IDLE;
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end

   // idle count: high bit times, restarted by low bits, or by every frame bit when idle_count_type is set
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         idle_cnt_r <= 4'h0;
      else if (tick && (rx_ph_r == TICKS_LAST))
      begin
         case (rx_state_r)
            RX_IDLE:
               if (idle_cnt_r != CHAR_BITS_9 + LONG_BRK_ADD)
                  idle_cnt_r <= idle_cnt_r + 4'h1;
            RX_DATA:
               idle_cnt_r <= (rx_in && !opt_r.idle_count_type)
                             ? idle_cnt_r + 4'h1 : 4'h0;
            RX_STOP:
               idle_cnt_r <= (rx_in && !opt_r.idle_count_type)
                             ? idle_cnt_r + 4'h1 : 4'h0;
            default: idle_cnt_r <= 4'h0;
         endcase
      end
      else if (rx_state_r == RX_START)
         idle_cnt_r <= 4'h1;
   end

   // ------------------------------
   // receive flags; a set in the clearing cycle wins
   // ------------------------------
   assign rx_clear = rd && (addr == OFS_DATA) && rd_armed_r;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rx_data_r    <= 8'h00;
         rx_ninth_r   <= 1'b0;
         rx_buffer_full_flag_r       <= 1'b0;
         idle_r       <= 1'b0;
         overrun_r    <= 1'b0;
         framing_r    <= 1'b0;
         parity_err_r <= 1'b0;
         idle_armed_r <= 1'b0;
         rd_armed_r   <= 1'b0;
      end
      else
      begin
         if (rd && (addr == OFS_STATUS))
            rd_armed_r <= 1'b1;
         else if (rx_clear)
            rd_armed_r <= 1'b0;
         if (rx_clear)
         begin
            rx_buffer_full_flag_r       <= 1'b0;
            idle_r       <= 1'b0;
            overrun_r    <= 1'b0;
            framing_r    <= 1'b0;
            parity_err_r <= 1'b0;
         end
         if ((rx_state_r == RX_IDLE) && idle_armed_r && !en_r.receiver_standby
             && (idle_cnt_r == char_len(opt_r.nine_bit_mode)))
         begin
            idle_r       <= 1'b1;
            idle_armed_r <= 1'b0;
         end
         if (rx_accept && rx_buffer_full_flag_r && !rx_clear)
            overrun_r <= 1'b1;
         else if (rx_accept)
         begin
            rx_buffer_full_flag_r       <= 1'b1;
            idle_armed_r <= 1'b1;
            rx_data_r    <= opt_r.nine_bit_mode ? rx_sh_r[7:0] : rx_sh_r[8:1];
            rx_ninth_r   <= opt_r.nine_bit_mode && rx_sh_r[8];
            framing_r    <= !rx_in;
            parity_err_r <= opt_r.parity_enable && (opt_r.parity_odd_select
                            ^ (opt_r.nine_bit_mode ? ones_odd(rx_sh_r)
                               : ones_odd({1'b0, rx_sh_r[8:1]})));
         end
      end
   end

   // ------------------------------
   // read port, interrupt request, receive pin ownership
   // ------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata        <= 8'h00;
         irq          <= 1'b0;
         rx_pin_owned <= 1'b0;
      end
      else
      begin
         irq <= (tx_buffer_empty_flag_r && en_r.tx_empty_irq_en) || (tc_r && en_r.tx_done_irq_en)
                || (rx_buffer_full_flag_r && en_r.rx_full_irq_en)
                || (idle_r && en_r.idle_line_irq_en);
         rx_pin_owned <= en_r.receive_enable && !opt_r.loop_select;
         rdata <= 8'h00;
         if (rd)
         begin
            case (addr)
               OFS_OPTIONS: rdata <= opt_r;
               OFS_ENABLES: rdata <= en_r;
               OFS_STATUS:  rdata <= {tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, idle_r, overrun_r,
                                      1'b0, framing_r, parity_err_r};
               OFS_DATA:    rdata <= rx_data_r;
               OFS_DIV_HI:  rdata <= {3'b000, divisor_r[12:8]};
               OFS_DIV_LO:  rdata <= divisor_r[7:0];
               OFS_EXTRA:   rdata <= {4'h0, rx_ninth_r, extra_r};
               default:     rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: logic/sci_uart_pkg.sv
package sci_uart_pkg;

   // ------------------------------
   // register map
   // ------------------------------
   localparam logic [2:0] OFS_OPTIONS  = 3'h0;
   localparam logic [2:0] OFS_ENABLES  = 3'h1;
   localparam logic [2:0] OFS_STATUS   = 3'h2;
   localparam logic [2:0] OFS_DATA     = 3'h3;
   localparam logic [2:0] OFS_DIV_HI   = 3'h4;
   localparam logic [2:0] OFS_DIV_LO   = 3'h5;
   localparam logic [2:0] OFS_EXTRA    = 3'h6;

   // ------------------------------
   // reset values
   // ------------------------------
   localparam logic [7:0]  RST_OPTIONS = 8'h00;
   localparam logic [7:0]  RST_ENABLES = 8'h00;
   localparam logic [12:0] RST_DIVISOR = 13'h0004;

   // ------------------------------
   // status and extra register bit positions
   // ------------------------------
   localparam int ST_TX_BUFFER_EMPTY_FLAG    = 7;
   localparam int ST_TC      = 6;
   localparam int ST_RX_BUFFER_FULL_FLAG    = 5;
   localparam int ST_IDLE    = 4;
   localparam int ST_OVERRUN = 3;
   localparam int ST_FRAMING = 1;
   localparam int ST_PARITY  = 0;
   localparam int EX_LONG_BRK = 0;
   localparam int EX_SW_DIR   = 1;
   localparam int EX_TX_NINTH = 2;
   localparam int EX_RX_NINTH = 3;

   // ------------------------------
   // timing counts, in sixteenth-bit ticks and bit times
   // ------------------------------
   localparam logic [3:0] TICKS_LAST   = 4'hF;
   localparam logic [3:0] TICKS_MID    = 4'h7;
   localparam logic [3:0] CHAR_BITS_8  = 4'hA;
   localparam logic [3:0] CHAR_BITS_9  = 4'hB;
   localparam logic [3:0] LONG_BRK_ADD = 4'h3;

   // ------------------------------
   // control register layouts
   // ------------------------------
   typedef struct packed {
      logic loop_select;
      logic wait_clock_freeze;
      logic receiver_source_select;
      logic nine_bit_mode;
      logic wake_address_mark;
      logic idle_count_type;
      logic parity_enable;
      logic parity_odd_select;
   } ctrl_options_s;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_full_irq_en;
      logic idle_line_irq_en;
      logic transmit_enable;
      logic receive_enable;
      logic receiver_standby;
      logic send_break;
   } ctrl_enables_s;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01
   } tx_state_e;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_e;

endpackage

// File: test/sci_uart_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sci_uart_checker
   import sci_uart_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // register port
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // pins
   input wire logic       tx_pin_out,
   input wire logic       tx_pin_oe,
   input wire logic       rx_pin_owned,
   input wire logic       wait_mode
);
   ctrl_options_s opt_r;
   ctrl_enables_s en_r;
   logic          dir_r;
   logic          own_w;
   logic          oe_w;
   logic          sw_w;
   logic          frz_w;

   // ------------------------------------------------------------
   // shadow of written controls
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         opt_r <= RST_OPTIONS;
         en_r  <= RST_ENABLES;
         dir_r <= 1'b0;
      end
      else if (wr)
      begin
         if (addr == OFS_OPTIONS)
            opt_r <= wdata;
         if (addr == OFS_ENABLES)
            en_r <= wdata;
         if (addr == OFS_EXTRA)
            dir_r <= wdata[EX_SW_DIR];
      end
   end

   assign own_w = en_r.receive_enable & ~opt_r.loop_select;
   assign sw_w  = opt_r.loop_select & opt_r.receiver_source_select;
   assign oe_w  = en_r.transmit_enable & ~sw_w;
   assign frz_w = wait_mode & opt_r.wait_clock_freeze;

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   opt_back_a: assert property (rd && addr == OFS_OPTIONS |=> rdata == $past(opt_r))
      else $error("options readback wrong");
   // standby is masked: hardware may clear it on wakeup
   en_back_a: assert property (rd && addr == OFS_ENABLES |=>
      (rdata & 8'hFD) == ($past(en_r) & 8'hFD)) else $error("enables readback wrong");
   rx_own_a: assert property (own_w [*3] |-> rx_pin_owned)
      else $error("rx pin not taken");
   rx_free_a: assert property (!own_w [*3] |-> !rx_pin_owned)
      else $error("rx pin not released");
   tx_drive_a: assert property (oe_w [*3] |-> tx_pin_oe)
      else $error("tx pin not driven");
   sw_listen_a: assert property (sw_w && !dir_r [*3] |-> !tx_pin_oe)
      else $error("single wire pin driven");
   sw_drive_a: assert property (sw_w && dir_r && en_r.transmit_enable [*3] |-> tx_pin_oe)
      else $error("single wire pin not driven");
   tx_release_a: assert property ($fell(tx_pin_oe) |-> tx_pin_out && $past(tx_pin_out))
      else $error("tx pin released mid frame");
   wait_freeze_a: assert property (frz_w [*4] |-> $stable(tx_pin_out))
      else $error("line moved while frozen");
endmodule

bind sci_uart_control_options sci_uart_checker chk_i (.clk, .sys_rst, .addr, .wdata, .wr, .rd,
   .rdata, .tx_pin_out, .tx_pin_oe, .rx_pin_owned, .wait_mode);

`default_nettype wire

// File: test/far_end.sv
`timescale 1ns/1ps
`default_nettype none

module far_end
(
   // link pins
   input  wire logic       clk,
   input  wire logic       line_in,
   output var  logic       line_out,
   // received frames
   output var  logic [7:0] got,
   output var  logic [7:0] got_cnt
);
   // divisor 1 gives sixteen clocks a bit
   localparam int BIT = 16;
   logic [7:0] sh;

   initial
   begin
      line_out = 1'b1;
      got      = 8'h00;
      got_cnt  = 8'h00;
   end

   // frames with a low stop bit are dropped, so the bench times out
   always
   begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge clk);
         sh[i] = line_in;
      end
      repeat (BIT) @(posedge clk);
      if (line_in === 1'b1)
      begin
         got     <= sh;
         got_cnt <= got_cnt + 8'h01;
      end
   end

   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         line_out <= f[i];
         repeat (BIT) @(posedge clk);
      end
   endtask
endmodule

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import sci_uart_pkg::*;
;
   logic       clk;
   logic       sys_rst;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic       wait_mode;
   logic [7:0] rdata;
   logic       tx_pin_out;
   logic       tx_pin_oe;
   logic       rx_pin_owned;
   logic       irq;
   wire        rx_line;
   logic [7:0] got;
   logic [7:0] got_cnt;
   logic [7:0] c;
   logic [7:0] s;
   int         mismatches;
   int         total_checks;
   // released pin floats high through the pull-up
   wire        tx_line = tx_pin_oe ? tx_pin_out : 1'b1;
   logic [7:0] opt_t [3] = '{8'h80, 8'h82, 8'h83};
   logic [7:0] dat_t [3] = '{8'h3C, 8'h07, 8'h07};
   logic [7:0] exp_t [3] = '{8'h3C, 8'h87, 8'h07};

   sci_uart_control_options dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
      .tx_pin_in(tx_line), .rx_pin_in(rx_line), .rx_pin_owned(rx_pin_owned),
      .wait_mode(wait_mode), .irq(irq));
   far_end far (.clk(clk), .line_in(tx_line), .line_out(rx_line), .got(got), .got_cnt(got_cnt));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, e);
   endtask

   // polls status; a flag that never comes ends the run
   task automatic wait_flag(input int b);
      logic [7:0] d;
      int         n;
      d = 8'h00;
      n = 0;
      while (d[b] !== 1'b1 && n < 400)
      begin
         rd_reg(OFS_STATUS, d);
         n++;
      end
      if (n >= 400)
      begin
         mismatches++;
         close_out();
      end
   endtask

   task automatic wait_far(input logic [7:0] c0);
      int n;
      n = 0;
      while (got_cnt === c0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000)
      begin
         mismatches++;
         close_out();
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {sys_rst, addr, wdata, wr, rd, wait_mode} = {1'b1, 3'h0, 8'h00, 3'b000};
      mismatches = 0;
      total_checks = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(OFS_OPTIONS, RST_OPTIONS);
      rd_chk(OFS_ENABLES, RST_ENABLES);
      rd_chk(OFS_STATUS, 8'hC0);
      wr_reg(3'h7, 8'hFF);
      rd_chk(3'h7, 8'h00);
      wr_reg(OFS_STATUS, 8'h00);
      rd_chk(OFS_STATUS, 8'hC0);
      $display("test reset done");
      wr_reg(OFS_DIV_HI, 8'h00);
      wr_reg(OFS_DIV_LO, 8'h01);
      wr_reg(OFS_ENABLES, 8'h88);
      repeat (3) @(posedge clk);
      chk({7'h00, irq}, 8'h01);
      c = got_cnt;
      wr_reg(OFS_DATA, 8'h5A);
      wait_flag(ST_TX_BUFFER_EMPTY_FLAG);
      rd_chk(OFS_STATUS, 8'h80);
      wr_reg(OFS_ENABLES, 8'h00);
      wait_far(c);
      repeat (16) @(posedge clk);
      chk(got, 8'h5A);
      chk({7'h00, irq, tx_pin_oe}, 8'h00);
      rd_chk(OFS_STATUS, 8'hC0);
      $display("test transmit done");
      wr_reg(OFS_OPTIONS, 8'h20);
      wr_reg(OFS_ENABLES, 8'h24);
      repeat (3) @(posedge clk);
      chk({7'h00, rx_pin_owned}, 8'h01);
      far.send(8'h96);
      wait_flag(ST_RX_BUFFER_FULL_FLAG);
      chk({7'h00, irq}, 8'h01);
      rd_chk(OFS_DATA, 8'h96);
      $display("test receive done");
      wr_reg(OFS_ENABLES, 8'h0C);
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(OFS_OPTIONS, opt_t[i]);
         wr_reg(OFS_DATA, dat_t[i]);
         chk({7'h00, rx_pin_owned}, 8'h00);
         wait_flag(ST_RX_BUFFER_FULL_FLAG);
         rd_chk(OFS_DATA, exp_t[i]);
      end
      $display("test loop done");
      wr_reg(OFS_OPTIONS, 8'h88);
      wr_reg(OFS_ENABLES, 8'h0E);
      wr_reg(OFS_DATA, 8'h01);
      wait_flag(ST_TC);
      rd_reg(OFS_STATUS, s);
      chk(s & 8'h20, 8'h00);
      wr_reg(OFS_DATA, 8'h81);
      wait_flag(ST_RX_BUFFER_FULL_FLAG);
      rd_chk(OFS_DATA, 8'h81);
      rd_chk(OFS_ENABLES, 8'h0C);
      $display("test standby done");
      wr_reg(OFS_OPTIONS, 8'hE0);
      repeat (4) @(posedge clk);
      chk({7'h00, tx_pin_oe}, 8'h00);
      wr_reg(OFS_EXTRA, 8'h02);
      repeat (4) @(posedge clk);
      chk({7'h00, tx_pin_oe}, 8'h01);
      wait_mode <= 1'b1;
      repeat (8) @(posedge clk);
      chk({7'h00, tx_pin_out}, 8'h01);
      wait_mode <= 1'b0;
      $display("test single wire done");
      close_out();
   end
endmodule

`default_nettype wire
